// ==== rtl/burst_flash_consts.svh ====
// Constants for the burst flash bus interface
`ifndef BURST_FLASH_CONSTS_SVH
`define BURST_FLASH_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define ADDR_W 20
`define DATA_W 16
`define CNT_W 5
`define WAIT_W 4
`define PAGE_HI 19
`define PAGE_LO 5
`define OFS_HI 4

// ----------------------------------------
// Counter values
// ----------------------------------------
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_LAST 5'h1f
`define WAIT_ZERO 4'h0
`define WAIT_ONE 4'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define INIT_ACCESS_NS 65
`define BURST_ACCESS_NS 17
// Longest times, so cycle counts round down
`define INIT_WAIT_CYC (`INIT_ACCESS_NS / `CLK_PERIOD_NS)
`define BURST_WAIT_CYC (`BURST_ACCESS_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/burst_flash_pkg.sv ====
// Types shared by the burst flash bus interface
`default_nettype none
`include "burst_flash_consts.svh"
package burst_flash_pkg;
	typedef logic [`ADDR_W-1:0] word_addr_t;
	typedef logic [`DATA_W-1:0] word_t;
	typedef logic [`CNT_W-1:0] burst_cnt_t;
	typedef logic [`WAIT_W-1:0] wait_cnt_t;
	typedef enum logic [1:0] {
		ST_ASYNC = 2'h0,
		ST_IDLE = 2'h1,
		ST_INIT = 2'h3,
		ST_BURST = 2'h2
	} burst_state_e;
endpackage
`default_nettype wire

// ==== rtl/cmd_if.sv ====
// Carrier for captured command words between the bus logic and its buffer
`timescale 1ns/100ps
`default_nettype none
interface cmd_if;
	import burst_flash_pkg::*;
	logic valid;
	logic ready;
	word_addr_t addr;
	word_t data;
	modport src (output valid, output addr, output data, input ready);
	modport sink (input valid, input addr, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/cmd_skid_buf.sv ====
// Two-entry command buffer with registered outputs
`timescale 1ns/100ps
`default_nettype none
module cmd_skid_buf
	import burst_flash_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// Filling and draining sides
	cmd_if.sink in_p,
	cmd_if.src out_p
);
	logic out_valid_q;
	logic spare_valid_q;
	word_addr_t out_addr_q;
	word_addr_t spare_addr_q;
	word_t out_data_q;
	word_t spare_data_q;
	logic in_fire;

	// Ready is registered so the filling side never sees a combinational path
	assign in_fire = in_p.valid && !spare_valid_q;
	assign in_p.ready = !spare_valid_q;
	assign out_p.valid = out_valid_q;
	assign out_p.addr = out_addr_q;
	assign out_p.data = out_data_q;

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			out_valid_q <= 1'b0;
			spare_valid_q <= 1'b0;
		end else if (!out_valid_q || out_p.ready) begin
			if (spare_valid_q) begin
				out_valid_q <= 1'b1;
				spare_valid_q <= 1'b0;
			end else begin
				out_valid_q <= in_fire;
			end
		end else if (in_fire) begin
			spare_valid_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_addr_q <= '0;
			out_data_q <= '0;
			spare_addr_q <= '0;
			spare_data_q <= '0;
		end else if (!out_valid_q || out_p.ready) begin
			out_addr_q <= spare_valid_q ? spare_addr_q : in_p.addr;
			out_data_q <= spare_valid_q ? spare_data_q : in_p.data;
		end else if (in_fire) begin
			spare_addr_q <= in_p.addr;
			spare_data_q <= in_p.data;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/burst_flash_bus.sv ====
// Bus interface of a burst-mode word flash: async reads, command writes, linear-32 bursts
`timescale 1ns/100ps
`default_nettype none
`include "burst_flash_consts.svh"
module burst_flash_bus
	import burst_flash_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Flash pins
	input wire logic hw_reset_n,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic load_start_addr_n,
	input wire logic advance_word_n,
	input wire word_addr_t word_address,
	input wire word_t data_bus_i,
	output word_t data_bus_o,
	output logic data_bus_oe_n,
	output logic last_word_flag_n,
	output logic ready_busy_n,
	// Array port
	output word_addr_t array_addr,
	input wire word_t array_rdata,
	// Command path to the internal state machine
	output logic cmd_valid,
	input wire logic cmd_ready,
	output word_addr_t cmd_addr,
	output word_t cmd_data,
	input wire logic burst_on,
	input wire logic burst_off,
	input wire logic cmd_reset,
	output logic array_read_mode
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	burst_state_e state_q;
	word_addr_t base_q;
	burst_cnt_t cnt_q;
	wait_cnt_t wait_q;
	word_addr_t array_addr_q;
	word_t data_q;
	logic oe_n_q;
	logic last_n_q;
	logic busy_n_q;
	logic wr_cycle_q;
	logic push_q;
	word_addr_t cmd_addr_q;
	word_t cmd_data_q;
	logic read_mode_q;

	logic sel;
	logic in_burst;
	logic load_acc;
	logic adv_acc;
	logic quiet;
	logic wr_cycle;
	logic wr_start;
	logic latch_now;
	logic rd_drive;
	logic follow_addr;

	cmd_if in_if ();
	cmd_if out_if ();

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Select and enables are plain levels each cycle, no edge alignment assumed
	assign sel = hw_reset_n && !chip_sel_n;
	assign in_burst = (state_q != ST_ASYNC);
	assign load_acc = in_burst && sel && write_en_n && !load_start_addr_n;
	assign adv_acc = (state_q == ST_BURST) && sel && write_en_n && load_start_addr_n
		&& !advance_word_n;
	assign quiet = sel && write_en_n && load_start_addr_n && advance_word_n && !burst_off;
	assign wr_cycle = sel && !write_en_n && out_en_n;
	assign wr_start = wr_cycle && !wr_cycle_q;
	assign latch_now = (wait_q == `WAIT_ONE);
	assign rd_drive = sel && !out_en_n && write_en_n;
	assign follow_addr = (state_q == ST_ASYNC) || (state_q == ST_IDLE);

	// ----------------------------------------
	// Mode and burst sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !hw_reset_n) begin
			state_q <= ST_ASYNC;
		end else begin
			case (state_q)
				ST_ASYNC: begin
					if (burst_on) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (burst_off) begin
						state_q <= ST_ASYNC;
					end else if (load_acc) begin
						state_q <= ST_INIT;
					end
				end
				ST_INIT: begin
					if (burst_off) begin
						state_q <= ST_ASYNC;
					end else if (!sel) begin
						state_q <= ST_IDLE;
					end else if (load_acc) begin
						state_q <= ST_INIT;
					end else if (latch_now) begin
						state_q <= ST_BURST;
					end
				end
				ST_BURST: begin
					if (burst_off) begin
						state_q <= ST_ASYNC;
					end else if (!sel) begin
						state_q <= ST_IDLE;
					end else if (load_acc) begin
						state_q <= ST_INIT;
					end
				end
				default: begin
					state_q <= ST_ASYNC;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Burst position
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			base_q <= '0;
			cnt_q <= `CNT_ZERO;
		end else if (load_acc) begin
			base_q <= word_address;
			cnt_q <= `CNT_ZERO;
		end else if (adv_acc) begin
			cnt_q <= cnt_q + `CNT_ONE;
		end
	end

	// Linear wrap keeps the upper address fixed and rolls the low five bits
	always_ff @(posedge clk) begin
		if (rst) begin
			array_addr_q <= '0;
		end else if (load_acc) begin
			array_addr_q <= word_address;
		end else if (adv_acc) begin
			array_addr_q <= {base_q[`PAGE_HI:`PAGE_LO],
				burst_cnt_t'(base_q[`OFS_HI:0] + cnt_q + `CNT_ONE)};
		end else if (follow_addr) begin
			array_addr_q <= word_address;
		end
	end

	// ----------------------------------------
	// Access timer
	// ----------------------------------------
	// Leaving burst mode drops any access in flight, so the timer never runs in async mode
	always_ff @(posedge clk) begin
		if (rst || !sel || burst_off || !in_burst) begin
			wait_q <= `WAIT_ZERO;
		end else if (load_acc) begin
			wait_q <= wait_cnt_t'(`INIT_WAIT_CYC);
		end else if (adv_acc) begin
			wait_q <= wait_cnt_t'(`BURST_WAIT_CYC);
		end else if (wait_q != `WAIT_ZERO) begin
			wait_q <= wait_q - `WAIT_ONE;
		end
	end

	// ----------------------------------------
	// Output word and end-of-burst flag
	// ----------------------------------------
	// In burst the word changes only when an access completes, so it is held across suspend
	always_ff @(posedge clk) begin
		if (rst) begin
			data_q <= '0;
		end else if (follow_addr) begin
			data_q <= array_rdata;
		end else if (latch_now) begin
			data_q <= array_rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !in_burst || !sel) begin
			last_n_q <= 1'b1;
		end else if (latch_now) begin
			last_n_q <= (cnt_q != `CNT_LAST);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= !rd_drive;
		end
	end

	// ----------------------------------------
	// Command latches
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_cycle_q <= 1'b0;
		end else begin
			wr_cycle_q <= wr_cycle;
		end
	end

	// One capture per write cycle; a write met by a full buffer is dropped and shows as busy
	always_ff @(posedge clk) begin
		if (rst || !hw_reset_n) begin
			push_q <= 1'b0;
		end else begin
			push_q <= wr_start && in_if.ready;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_addr_q <= '0;
			cmd_data_q <= '0;
		end else if (wr_start) begin
			cmd_addr_q <= word_address;
			cmd_data_q <= data_bus_i;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_n_q <= 1'b1;
		end else begin
			busy_n_q <= in_if.ready;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !hw_reset_n) begin
			read_mode_q <= 1'b1;
		end else if (push_q && in_if.ready) begin
			read_mode_q <= 1'b0;
		end else if (cmd_reset) begin
			read_mode_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Command buffer
	// ----------------------------------------
	assign in_if.valid = push_q;
	assign in_if.addr = cmd_addr_q;
	assign in_if.data = cmd_data_q;
	assign out_if.ready = cmd_ready;

	cmd_skid_buf u_buf (
		.clk(clk),
		.rst(rst),
		.flush(!hw_reset_n),
		.in_p(in_if.sink),
		.out_p(out_if.src)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign data_bus_o = data_q;
	assign data_bus_oe_n = oe_n_q;
	assign last_word_flag_n = last_n_q;
	assign ready_busy_n = busy_n_q;
	assign array_addr = array_addr_q;
	assign cmd_valid = out_if.valid;
	assign cmd_addr = out_if.addr;
	assign cmd_data = out_if.data;
	assign array_read_mode = read_mode_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_load;
		load_acc && !burst_off;
	endsequence

	sequence s_init_wait;
		quiet[*8];
	endsequence

	sequence s_step_wait;
		quiet[*2];
	endsequence

	a_load_capture: assert property (s_load |=> array_addr_q == $past(word_address)
		&& cnt_q == `CNT_ZERO && state_q == ST_INIT)
		else $error("start address not captured on load");

	a_first_word: assert property (s_load ##1 s_init_wait |=> state_q == ST_BURST
		&& data_q == $past(array_rdata))
		else $error("first burst word not presented on time");

	a_advance_step: assert property (adv_acc |=> cnt_q == $past(cnt_q) + `CNT_ONE)
		else $error("advance did not step the counter");

	a_burst_word: assert property (adv_acc ##1 s_step_wait |=> data_q == $past(array_rdata))
		else $error("stepped word not presented on time");

	a_hold_word: assert property (state_q == ST_BURST && quiet && wait_q == `WAIT_ZERO
		|=> $stable(data_q) && $stable(cnt_q))
		else $error("word changed without advance");

	a_last_flag: assert property (latch_now && sel && in_burst
		|=> last_word_flag_n == ($past(cnt_q) != `CNT_LAST))
		else $error("end-of-burst flag wrong");

	a_wrap_start: assert property (adv_acc && cnt_q == `CNT_LAST
		|=> cnt_q == `CNT_ZERO && array_addr_q[`OFS_HI:0] == base_q[`OFS_HI:0])
		else $error("burst did not wrap to start word");

	a_bus_float: assert property (!rd_drive |=> data_bus_oe_n)
		else $error("data bus driven without select and enable");

	a_hw_reset: assert property (!hw_reset_n |=> state_q == ST_ASYNC
		&& array_read_mode && data_bus_oe_n && !push_q)
		else $error("hardware reset did not abort");

	a_cmd_capture: assert property (wr_start && in_if.ready |=> push_q
		&& cmd_addr_q == $past(word_address) && cmd_data_q == $past(data_bus_i) ##1 !push_q)
		else $error("write cycle not latched once");

	a_burst_kept: assert property (in_burst && hw_reset_n && !burst_off |=> in_burst)
		else $error("burst mode left without disable or reset");

	a_async_ignore: assert property (state_q == ST_ASYNC && !burst_on
		|=> state_q == ST_ASYNC && $stable(cnt_q) && $stable(wait_q))
		else $error("strobes acted in asynchronous mode");
endmodule
`default_nettype wire

// ==== verif/flash_side_model.sv ====
// Array and command-consumer model on the far side of the flash bus block
`timescale 1ns/100ps
`default_nettype none
module flash_side_model
	import burst_flash_pkg::*;
(
	// Clock
	input wire logic clk,
	// Array side
	input wire word_addr_t array_addr,
	output word_t array_rdata,
	// Command side
	input wire logic stall,
	input wire logic cmd_valid,
	output logic cmd_ready,
	output logic [7:0] taken_cnt
);
	// ----------------------------------------
	// Array contents
	// ----------------------------------------
	// Upper address bits folded in, so a wrong page shows in the data
	assign array_rdata = array_addr[15:0] ^ {array_addr[19:16], 12'h000};

	// ----------------------------------------
	// Command consumer
	// ----------------------------------------
	assign cmd_ready = !stall;
	initial taken_cnt = 8'h00;
	always @(posedge clk) begin
		if (cmd_valid === 1'b1 && cmd_ready) begin
			taken_cnt <= taken_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verif/test_burst_flash_bus.sv ====
// Self-checking bench for the burst flash bus interface
`timescale 1ns/100ps
`default_nettype none
module test_burst_flash_bus;
	import burst_flash_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0, rst = 1'b1, hw_reset_n = 1'b1, chip_sel_n = 1'b1, out_en_n = 1'b1, write_en_n = 1'b1;
	logic load_start_addr_n = 1'b1, advance_word_n = 1'b1, burst_on = 1'b0, burst_off = 1'b0, cmd_reset = 1'b0;
	logic stall = 1'b0;
	word_addr_t word_address = 20'h00000;
	word_t data_bus_i = 16'h0000;
	word_t data_bus_o, array_rdata, cmd_data;
	word_addr_t array_addr, cmd_addr;
	logic data_bus_oe_n, last_word_flag_n, ready_busy_n, cmd_valid, cmd_ready, array_read_mode;
	logic [7:0] taken_cnt;
	int fails = 0, cmp_count = 0, cycles = 0, n;
	word_addr_t rows_a [4] = '{20'h00000, 20'hfffff, 20'h12345, 20'h8001f};
	word_t rows_d [4] = '{16'h0000, 16'h0fff, 16'h3345, 16'h801f};
	word_addr_t s = 20'h31452, s2 = 20'h0a01f;

	burst_flash_bus dut (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .write_en_n(write_en_n), .load_start_addr_n(load_start_addr_n),
		.advance_word_n(advance_word_n), .word_address(word_address), .data_bus_i(data_bus_i),
		.data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n), .last_word_flag_n(last_word_flag_n),
		.ready_busy_n(ready_busy_n), .array_addr(array_addr), .array_rdata(array_rdata),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.burst_on(burst_on), .burst_off(burst_off), .cmd_reset(cmd_reset), .array_read_mode(array_read_mode));
	flash_side_model side (.clk(clk), .array_addr(array_addr), .array_rdata(array_rdata), .stall(stall),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .taken_cnt(taken_cnt));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			summarize();
		end
	end
	task summarize;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	task edges(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Word expected at burst position k from start b, wrapping in its 32-word page
	function word_t bw(input word_addr_t b, input int k);
		word_addr_t a;
		a = {b[19:5], b[4:0] + 5'(k)};
		return a[15:0] ^ {a[19:16], 12'h000};
	endfunction
	task wr(input word_addr_t a, input word_t d);
		word_address = a;
		data_bus_i = d;
		write_en_n = 1'b0;
		edges(2);
		write_en_n = 1'b1;
		edges(2);
	endtask
	task load(input word_addr_t a);
		word_address = a;
		load_start_addr_n = 1'b0;
		edges(1);
		load_start_addr_n = 1'b1;
		edges(9);
	endtask
	// Single-edge advance, then wait out the burst access
	task adv;
		advance_word_n = 1'b0;
		edges(1);
		advance_word_n = 1'b1;
		edges(4);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		edges(20);
		rst = 1'b0;
		check(data_bus_oe_n, 1'b1, "oe_n after reset");
		check({last_word_flag_n, ready_busy_n, cmd_valid}, 3'b110, "flags after reset");
		check(array_read_mode, 1'b1, "read mode after reset");
		// Async reads; strobes held active must be ignored outside burst mode
		chip_sel_n = 1'b0;
		out_en_n = 1'b0;
		load_start_addr_n = 1'b0;
		advance_word_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			word_address = rows_a[i];
			edges(3);
			check(data_bus_o, rows_d[i], "async word");
			check({data_bus_oe_n, last_word_flag_n}, 2'b01, "async pins");
		end
		load_start_addr_n = 1'b1;
		advance_word_n = 1'b1;
		out_en_n = 1'b1;
		edges(2);
		check(data_bus_oe_n, 1'b1, "oe high floats");
		// Command writes into a stalled consumer until the buffer refuses
		stall = 1'b1;
		n = 0;
		for (int i = 0; i < 4; i++) begin
			if (ready_busy_n === 1'b1) begin
				wr(20'h00555 + 20'(i), 16'h00aa + 16'(i));
				n++;
			end
		end
		check(ready_busy_n, 1'b0, "buffer full");
		check({cmd_valid, cmd_addr, cmd_data}, {1'b1, 20'h00555, 16'h00aa}, "first command");
		check(array_read_mode, 1'b0, "read mode left");
		wr(20'h00999, 16'h0099);
		stall = 1'b0;
		edges(12);
		check(taken_cnt, 8'(n), "drained count");
		check({cmd_valid, ready_busy_n}, 2'b01, "buffer empty");
		cmd_reset = 1'b1;
		edges(1);
		cmd_reset = 1'b0;
		edges(2);
		check(array_read_mode, 1'b1, "read mode back");
		// Full 32-word burst with wrap
		out_en_n = 1'b0;
		burst_on = 1'b1;
		edges(1);
		burst_on = 1'b0;
		load(s);
		check(data_bus_o, bw(s, 0), "first burst word");
		check({data_bus_oe_n, last_word_flag_n}, 2'b01, "burst pins");
		for (int k = 1; k < 33; k++) begin
			adv();
			check(data_bus_o, bw(s, k), "burst word");
			check(last_word_flag_n, 1'(k != 31), "last flag");
		end
		edges(5);
		check(data_bus_o, bw(s, 0), "held word");
		// Suspend, step while floated, resume
		out_en_n = 1'b1;
		edges(2);
		check(data_bus_oe_n, 1'b1, "suspend floats");
		adv();
		check(data_bus_oe_n, 1'b1, "float while stepping");
		out_en_n = 1'b0;
		edges(2);
		check(data_bus_o, bw(s, 1), "resume same word");
		adv();
		check(data_bus_o, bw(s, 2), "resume stepping");
		// Back-to-back advances
		advance_word_n = 1'b0;
		edges(3);
		advance_word_n = 1'b1;
		edges(4);
		check(data_bus_o, bw(s, 5), "three advances");
		// Restart at the top offset of a page
		load(s2);
		check({data_bus_o, last_word_flag_n}, {bw(s2, 0), 1'b1}, "restart");
		cmd_reset = 1'b1;
		edges(1);
		cmd_reset = 1'b0;
		adv();
		check(data_bus_o, bw(s2, 1), "burst after reset cmd");
		chip_sel_n = 1'b1;
		edges(2);
		check({data_bus_oe_n, last_word_flag_n}, 2'b11, "select high ends");
		chip_sel_n = 1'b0;
		burst_off = 1'b1;
		edges(1);
		burst_off = 1'b0;
		word_address = rows_a[2];
		edges(3);
		check(data_bus_o, rows_d[2], "async after disable");
		// Hardware reset in mid-burst
		burst_on = 1'b1;
		edges(1);
		burst_on = 1'b0;
		load(s);
		hw_reset_n = 1'b0;
		edges(2);
		check(data_bus_oe_n, 1'b1, "hw reset floats");
		hw_reset_n = 1'b1;
		load(s);
		check(data_bus_o, bw(s, 0), "async after hw reset");
		advance_word_n = 1'b0;
		word_address = rows_a[3];
		edges(3);
		check(data_bus_o, rows_d[3], "strobes ignored");
		summarize();
	end
endmodule
`default_nettype wire
